// *** core/fio_pkg.sv ***
package fio_pkg;
	// controller clock rate
	localparam int unsigned CLK_HZ        = 200_000_000;
	// one millisecond in clock cycles
	localparam int unsigned MS_CYCLES     = CLK_HZ / 1000;
	// filter time span, in milliseconds
	localparam int unsigned FILT_MIN_MS   = 1;
	localparam int unsigned FILT_MAX_MS   = 100;
	// filter time after reset, in milliseconds
	localparam logic [6:0]  FILT_RST_MS   = 7'h01;
	// outputs sharing one error policy
	localparam int unsigned GROUP_SIZE    = 8;
	// millisecond tick counter width
	localparam int unsigned TICK_W        = 18;
	// error policy encoding
	localparam logic        POL_CLEAR     = 1'b0;
	localparam logic        POL_HOLD      = 1'b1;
endpackage : fio_pkg

// *** core/fio_in_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// filter time and tick shared between top and the filter module
interface fio_in_if;
	logic       msTick;   // one-cycle pulse every millisecond
	logic [6:0] filtMs;   // filter time in milliseconds
	modport src (output msTick, output filtMs);
	modport dst (input msTick, input filtMs);
endinterface : fio_in_if
`default_nettype wire

// *** core/fio_filter.sv ***
`timescale 1ns/100ps
`default_nettype none
module fio_filter #(
	parameter int unsigned N = 16   // number of inputs
) (
	input  wire logic         clk,
	input  wire logic         reset,
	fio_in_if.dst             cfg,
	input  wire logic [N-1:0] rawSync,  // already synchronised pins
	output var  logic [N-1:0] filtered
);
	initial if (N < 1) $error("fio_filter: N must be at least 1");

	// whole state of the filter bank
	typedef struct packed {
		logic [N-1:0][6:0] stable;  // ms the pin has differed
		logic [N-1:0]      level;   // accepted level
	} fio_filt_t;

	fio_filt_t st_reg;   // registered state
	fio_filt_t st_next;  // next state

	// per-pin disagreement timer
	always_comb begin
		st_next = st_reg;
		for (int i = 0; i < N; i++) begin
			if (rawSync[i] == st_reg.level[i]) begin
				// pulse ended early: forget it
				st_next.stable[i] = 7'h00;
			end else if (cfg.msTick) begin
				if (st_reg.stable[i] + 7'h01 >= cfg.filtMs) begin
					// stayed changed over filtMs millisecond ticks
					st_next.level[i]  = rawSync[i];
					st_next.stable[i] = 7'h00;
				end else begin
					st_next.stable[i] = st_reg.stable[i] + 7'h01;
				end
			end
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign filtered = st_reg.level;

	// a change of accepted level needs a millisecond tick
	property p_filt_tick;
		@(posedge clk) disable iff (reset)
		(st_reg.level != $past(st_reg.level)) |-> $past(cfg.msTick);
	endproperty
	a_filt_tick: assert property (p_filt_tick)
		else $error("filtered level moved without a tick");
endmodule : fio_filter
`default_nettype wire

// *** core/fio_top.sv ***
// What this block does
// - pulses that do not span filtMs millisecond ticks are ignored
// - filter time settable from 1 to 100 ms
// - one clear/hold policy per eight outputs
// - clear policy turns group off on error
// - hold policy keeps group level on error
// - policy applies only with global hold setting
`timescale 1ns/100ps
`default_nettype none
module fio_top #(
	parameter int unsigned NIN    = 16,  // filtered inputs
	parameter int unsigned NGROUP = 2    // output groups of eight
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic [NIN-1:0]        inPins,     // raw field inputs
	input  wire logic [6:0]            filtMsSet,  // filter time, ms
	input  wire logic                  filtLoad,   // take filtMsSet
	input  wire logic [NGROUP*8-1:0]   outCmd,     // program outputs
	input  wire logic [NGROUP-1:0]     groupPol,   // 1 hold, 0 clear
	input  wire logic                  holdOnErr,  // global hold enable
	input  wire logic                  errStop,    // stopped on error
	output var  logic [NIN-1:0]        inFilt,     // filtered inputs
	output var  logic [NGROUP*8-1:0]   outPins,    // field outputs
	output var  logic [6:0]            filtMsCur,  // active filter time
	output var  logic                  filtBad     // last load refused
);
	localparam int unsigned NOUT = NGROUP * fio_pkg::GROUP_SIZE;
	initial if (NIN < 1 || NGROUP < 1)
		$error("fio_top: NIN and NGROUP must be at least 1");

	// whole state of the top
	typedef struct packed {
		logic [NIN-1:0]          sync1;   // first sync stage
		logic [NIN-1:0]          sync2;   // second sync stage
		logic [fio_pkg::TICK_W-1:0] div;  // millisecond divider
		logic                    tick;    // ms enable pulse
		logic [6:0]              filtMs;  // active filter time
		logic                    bad;     // refused load
		logic [NOUT-1:0]         outs;    // driven outputs
		logic [NIN-1:0]          inF;     // registered filtered inputs
	} fio_top_t;

	fio_top_t st_reg;   // registered state
	fio_top_t st_next;  // next state
	logic [NIN-1:0] filtOut;  // filter bank result

	fio_in_if cfgIf ();

	// true if the time lies in the allowed span
	function automatic logic filt_ok(input logic [6:0] ms);
		filt_ok = (ms >= 7'(fio_pkg::FILT_MIN_MS))
			&& (ms <= 7'(fio_pkg::FILT_MAX_MS));
	endfunction : filt_ok

	// next-state logic
	always_comb begin
		st_next       = st_reg;
		// two-stage synchroniser for the pins
		st_next.sync1 = inPins;
		st_next.sync2 = st_reg.sync1;
		// ms enable from a divider
		st_next.tick  = 1'b0;
		if (st_reg.div == fio_pkg::TICK_W'(fio_pkg::MS_CYCLES - 1)) begin
			st_next.div  = '0;
			st_next.tick = 1'b1;
		end else begin
			st_next.div = st_reg.div + 1'b1;
		end
		// filter time load, only within the span
		if (filtLoad) begin
			if (filt_ok(filtMsSet)) begin
				st_next.filtMs = filtMsSet;
				st_next.bad    = 1'b0;
			end else begin
				st_next.bad = 1'b1;
			end
		end
		// outputs per group
		for (int g = 0; g < NGROUP; g++) begin
			for (int b = 0; b < fio_pkg::GROUP_SIZE; b++) begin
				if (!errStop) begin
					st_next.outs[g*8+b] = outCmd[g*8+b];
				end else if (holdOnErr
					&& groupPol[g] == fio_pkg::POL_HOLD) begin
					st_next.outs[g*8+b] = st_reg.outs[g*8+b];
				end else begin
					st_next.outs[g*8+b] = 1'b0;
				end
			end
		end
		st_next.inF = filtOut;
	end

	// state register
	always_ff @(posedge clk) begin
		if (reset) begin
			st_reg        <= '0;
			st_reg.filtMs <= fio_pkg::FILT_RST_MS;
		end else begin
			st_reg <= st_next;
		end
	end

	assign cfgIf.msTick = st_reg.tick;
	assign cfgIf.filtMs = st_reg.filtMs;

	// filter bank; host keeps task cycle under filter time
	fio_filter #(.N(NIN)) uFilt (
		.clk      (clk),
		.reset    (reset),
		.cfg      (cfgIf),
		.rawSync  (st_reg.sync2),
		.filtered (filtOut)
	);

	assign inFilt    = st_reg.inF;
	assign outPins   = st_reg.outs;
	assign filtMsCur = st_reg.filtMs;
	assign filtBad   = st_reg.bad;

	// group 0 outputs off one cycle after error with clear policy
	property p_clear;
		@(posedge clk) disable iff (reset)
		(errStop && (!holdOnErr || groupPol[0] == fio_pkg::POL_CLEAR))
			|=> (outPins[7:0] == 8'h00);
	endproperty
	a_clear: assert property (p_clear)
		else $error("group not cleared on error");

	// held group 0 keeps its value across error cycles
	sequence s_hold_err;
		errStop && holdOnErr && groupPol[0] == fio_pkg::POL_HOLD;
	endsequence
	property p_hold;
		@(posedge clk) disable iff (reset)
		s_hold_err ##1 s_hold_err |=> $stable(outPins[7:0]);
	endproperty
	a_hold: assert property (p_hold)
		else $error("held group changed during error");

	// filter time always within the span
	property p_span;
		@(posedge clk) disable iff (reset)
		filtMsCur >= 7'h01 && filtMsCur <= 7'h64;
	endproperty
	a_span: assert property (p_span)
		else $error("filter time out of span");

	// bad load leaves filter time unchanged
	property p_refuse;
		@(posedge clk) disable iff (reset)
		(filtLoad && !filt_ok(filtMsSet)) |=> $stable(filtMsCur) && filtBad;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("out of span load accepted");

	// normal run passes commands through next cycle
	property p_run;
		@(posedge clk) disable iff (reset)
		!errStop |=> outPins == $past(outCmd);
	endproperty
	a_run: assert property (p_run)
		else $error("outputs not following command");

	// ms tick is one cycle wide
	property p_tick;
		@(posedge clk) disable iff (reset)
		st_reg.tick |=> !st_reg.tick;
	endproperty
	a_tick: assert property (p_tick)
		else $error("tick longer than one cycle");
endmodule : fio_top
`default_nettype wire

// *** dv/fio_field.sv ***
`timescale 1ns/100ps
`default_nettype none
// field switches: steady levels with optional contact bounce
module fio_field #(
	parameter int unsigned N = 16  // input points
) (
	input  wire logic         clk,
	input  wire logic [N-1:0] level,  // steady switch state
	input  wire logic [N-1:0] noise,  // points bouncing now
	output var  logic [N-1:0] inPins  // raw field lines
);
	// bounce inverts a line only while it is asked, so short pulses
	// stay far below any filter time in use
	always_ff @(posedge clk) begin
		inPins <= level ^ noise;
	end
endmodule : fio_field
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        clk       = 1'b0;   // 200 MHz clock
	logic        reset     = 1'b1;   // sync reset
	logic [15:0] level     = 16'h0;  // switch state
	logic [15:0] noise     = 16'h0;  // bounce mask
	logic [15:0] inPins;             // raw lines
	logic [6:0]  filtMsSet = 7'h00;  // filter request
	logic        filtLoad  = 1'b0;   // load strobe
	logic [15:0] outCmd    = 16'h0;  // program outputs
	logic [1:0]  groupPol  = 2'h0;   // per group policy
	logic        holdOnErr = 1'b0;   // global hold
	logic        errStop   = 1'b0;   // error stop
	logic        randOn    = 1'b0;   // random output traffic
	logic [15:0] inFilt;             // filtered inputs
	logic [15:0] outPins;            // field outputs
	logic [6:0]  filtMsCur;          // active filter time
	logic        filtBad;            // refused load
	logic [15:0] modelOut  = 16'h0;  // reference outputs
	int          seed      = 36;     // random seed
	int          mismatches = 0;     // failed compares
	int          checked   = 0;      // compares made
	int          expCur    = 1;      // reference filter time
	int          i;                  // loop index
	int          vals[5]   = '{0, 101, 100, 127, 1};  // load table

	// clock
	always #2.5 clk = ~clk;

	fio_field fio_field_i (.clk(clk), .level(level), .noise(noise),
		.inPins(inPins));
	fio_top fio_top_i (.clk(clk), .reset(reset), .inPins(inPins),
		.filtMsSet(filtMsSet), .filtLoad(filtLoad), .outCmd(outCmd),
		.groupPol(groupPol), .holdOnErr(holdOnErr), .errStop(errStop),
		.inFilt(inFilt), .outPins(outPins), .filtMsCur(filtMsCur),
		.filtBad(filtBad));

	// compare one result
	task automatic chk(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// counts, verdict, end of run
	task summarize;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	// random output traffic just after each edge
	always @(posedge clk) begin
		if (randOn)
			#1 {outCmd, groupPol, holdOnErr, errStop} = $random(seed);
	end

	// reference outputs: hold needs both settings, else clear
	always @(posedge clk) begin
		for (int g = 0; g < 2; g++) begin
			if (reset)
				modelOut[g*8+:8] = 8'h00;
			else if (!errStop)
				modelOut[g*8+:8] = outCmd[g*8+:8];
			else if (!(holdOnErr && groupPol[g]))
				modelOut[g*8+:8] = 8'h00;
		end
	end

	// every output result against the reference
	always @(negedge clk) chk("outPins", modelOut, outPins);

	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		#1 reset = 1'b0;
		chk("inFilt", 16'h0, inFilt);
		chk("filtMsCur", 16'h1, {9'h0, filtMsCur});
		chk("filtBad", 16'h0, {15'h0, filtBad});
		randOn = 1'b1;
		// back to back loads, in span and out of span
		filtLoad = 1'b1;
		for (i = 0; i < 5; i++) begin
			filtMsSet = vals[i];
			@(posedge clk);
			#1;
			if (vals[i] >= 1 && vals[i] <= 100)
				expCur = vals[i];
			chk("filtMsCur", expCur, {9'h0, filtMsCur});
			chk("filtBad", (vals[i] < 1 || vals[i] > 100), {15'h0, filtBad});
		end
		filtMsSet = 7'h03;
		@(posedge clk);
		#1 filtLoad = 1'b0;
		// bounce far shorter than three milliseconds
		noise = 16'hFFFF;
		repeat (1000) @(posedge clk);
		#1 noise = 16'h0000;
		repeat (2000) begin
			@(negedge clk);
			chk("inFilt", 16'h0, inFilt);
		end
		// one millisecond filter, steady change is taken
		filtMsSet = 7'h01;
		filtLoad = 1'b1;
		@(posedge clk);
		#1 filtLoad = 1'b0;
		level = 16'hA5C3;
		for (i = 0; i < 200020 && inFilt !== level; i++)
			@(posedge clk);
		#1 chk("inFilt", level, inFilt);
		// a wait that ran out counts as a mismatch
		if (i >= 200020)
			mismatches++;
		summarize();
	end
endmodule : tb
`default_nettype wire
